// ===== rtl/lpm_pkg.sv
// Constants, register map and helpers for the low-power mode controller.
// Assumes a single 100 MHz clock and an AXI4-Lite master on the register side.
package lpm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int DBNC_TIME_MS    = 20;
  localparam int DBNC_CYCLES     = DBNC_TIME_MS * (CLK_HZ / 1000);
  localparam int RST_PULSE_US    = 200;
  localparam int RST_CYCLES      = RST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W           = 24;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONV1  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONV2  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CHCFG  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQST  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQMSK = 8'h14;

  localparam int CORE_W           = 4;
  localparam int CONV1_PERMIT_BIT = 0;
  localparam int CONV1_CORE_LSB   = 4;
  localparam int CONV1_MAIN_BIT   = 8;
  localparam int CONV2_RED_LSB    = 0;
  localparam int CONV2_COREOFF_BIT = 4;
  localparam int CHCFG_AUA_BIT    = 7;
  localparam int ST_LOW_BIT       = 0;
  localparam int ST_WAIT_BIT      = 1;
  localparam int ST_BTN_BIT       = 2;
  localparam int ST_WARM_BIT      = 3;
  localparam int ST_CORE_OK_BIT   = 4;

  localparam int IRQ_W    = 3;
  localparam int IRQ_BTN  = 0;
  localparam int IRQ_WARM = 1;
  localparam int IRQ_EXIT = 2;

  localparam logic [CORE_W-1:0] CORE_NOM_RST = 4'h6;
  localparam logic [CORE_W-1:0] CORE_RED_RST = 4'h2;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // True for any offset the slave decodes
  function automatic logic lpm_mapped(input logic [ADDR_W-1:0] a);
    lpm_mapped = (a == ADDR_CONV1) || (a == ADDR_CONV2) || (a == ADDR_CHCFG) ||
                 (a == ADDR_STATUS) || (a == ADDR_IRQST) || (a == ADDR_IRQMSK);
  endfunction
endpackage

// ===== rtl/lpm_dbnc_if.sv
// Debounced button level and its edge pulses, debouncer to controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lpm_dbnc_if;
  logic level;
  logic rise;
  logic fall;
  modport drv (output level, rise, fall);
  modport use_side (input level, rise, fall);
endinterface

// ===== rtl/lpm_debounce.sv
// Two-flop synchroniser and stability counter for one button pin.
// Assumes the pin is fed active high; a change must persist LIMIT cycles.
`timescale 1ns/1ps
module lpm_debounce
  import lpm_pkg::*;
#(
  parameter int LIMIT = DBNC_CYCLES
) (
  input  wire logic    i_clk,
  input  wire logic    i_rst,
  input  wire logic    i_raw,
  lpm_dbnc_if.drv      dbnc
);
  logic             s1_q;
  logic             s2_q;
  logic             level_q;
  logic             rise_q;
  logic             fall_q;
  logic [CNT_W-1:0] cnt_q;
  logic             done;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= i_raw;
      s2_q <= s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  // Any bounce restarts the count, so short glitches never reach the level
  assign done = (cnt_q == CNT_W'(LIMIT - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (s2_q == level_q) begin
        cnt_q <= '0;
      end else if (done) begin
        cnt_q   <= '0;
        level_q <= s2_q;
        rise_q  <= s2_q;
        fall_q  <= !s2_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign dbnc.level = level_q;
  assign dbnc.rise  = rise_q;
  assign dbnc.fall  = fall_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_dbnc_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(level_q) |-> $past(done) && ($past(s2_q) == level_q))
    else $error("debounced level moved without a full stable count");
endmodule

// ===== rtl/lpm_ctrl.sv
// Low-power mode controller: sleep entry and exit, core rail select,
// button debounce, processor reset pulse, main rail strap and AXI4-Lite registers.
// Assumes one 100 MHz clock; the sleep, button, warm, strap, regulation and adapter pins are asynchronous and are synchronised here.
//
// Contract
// - Main rail default voltage follows strap: low gives 3.0 V, high 3.3 V.
// - Enter sleep only on rising edge of sleep request AND permit bit.
// - Sleep request is ignored while the permit bit is clear; the code still drives o_wait_mode from it then.
// - In sleep the core rail takes the reduced preset voltage.
// - With core-off-in-sleep set, the core rail is switched off in sleep.
// - Exit sleep on request low, permit clear, button or warm restart.
// - Sleep request also sets wait mode; adapter present needs always-use-adapter.
// - Button exit restores the core voltage held before sleep.
// - Button and warm restart inputs are debounced before use.
// - Debounced button activation raises a maskable interrupt event.
// - Warm restart pulses processor reset only while the core rail regulates.
// - Warm restart changes no configuration, only leaves sleep.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int DBNC_LIMIT = DBNC_CYCLES,
  parameter int RST_LEN    = RST_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_sleep_request,
  input  wire logic              i_push_button,
  input  wire logic              i_warm_restart_n,
  input  wire logic              i_main_default_strap,
  input  wire logic              i_core_in_reg,
  input  wire logic              i_adapter_present,
  output logic [CORE_W-1:0]      o_core_vsel,
  output logic                   o_core_en,
  output logic                   o_main_3v3,
  output logic                   o_processor_reset_n,
  output logic                   o_low_power,
  output logic                   o_wait_mode,
  output logic                   o_irq,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0]        sy1_q;
  logic [3:0]        sy2_q;
  logic              sleep_s;
  logic              strap_s;
  logic              core_ok_s;
  logic              adapter_s;
  logic              permit_q;
  logic [CORE_W-1:0] core_nom_q;
  logic [CORE_W-1:0] core_red_q;
  logic              coreoff_q;
  logic              aua_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_st_q;
  logic [IRQ_W-1:0]  irq_set;
  logic [1:0]        strap_cnt_q;
  logic              strap_load;
  logic              gate_q;
  logic              enter_rise;
  logic              exit_ev;
  logic              low_q;
  logic [CNT_W-1:0]  rst_cnt_q;
  logic              rst_start;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [ADDR_W-1:0] araddr_q;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_b0;
  logic [31:0]       rd_word;

  lpm_dbnc_if btn ();
  lpm_dbnc_if warm ();

  // ----------------------------------------------------------------
  // Pin synchronisers and debouncers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
    end else begin
      sy1_q <= {i_adapter_present, i_core_in_reg, i_main_default_strap, i_sleep_request};
      sy2_q <= sy1_q;
    end
  end

  assign sleep_s   = sy2_q[0];
  assign strap_s   = sy2_q[1];
  assign core_ok_s = sy2_q[2];
  assign adapter_s = sy2_q[3];

  lpm_debounce #(.LIMIT(DBNC_LIMIT)) u_btn (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_raw (i_push_button),
    .dbnc  (btn)
  );

  // Inverted so that the pulled-up idle level reads as inactive
  lpm_debounce #(.LIMIT(DBNC_LIMIT)) u_warm (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_raw (!i_warm_restart_n),
    .dbnc  (warm)
  );

  // ----------------------------------------------------------------
  // Main rail strap
  // ----------------------------------------------------------------
  // Captured once after release, when the synchroniser holds the pin level
  assign strap_load = (strap_cnt_q == STRAP_WAIT);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt_q <= 2'h0;
      o_main_3v3  <= 1'b0;
    end else begin
      if (strap_cnt_q <= STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (strap_load) begin
        o_main_3v3 <= strap_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep state
  // ----------------------------------------------------------------
  // Edge, not level: after any exit the host must make a fresh edge to return
  assign enter_rise = sleep_s && permit_q && !gate_q;
  assign exit_ev    = !sleep_s || !permit_q || btn.rise || warm.rise;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_q <= 1'b0;
      low_q  <= 1'b0;
    end else begin
      gate_q <= sleep_s && permit_q;
      if (low_q && exit_ev) begin
        low_q <= 1'b0;
      end else if (enter_rise && !exit_ev) begin
        low_q <= 1'b1;
      end
    end
  end

  // Core rail and mode outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_core_vsel <= CORE_NOM_RST;
      o_core_en   <= 1'b1;
      o_low_power <= 1'b0;
      o_wait_mode <= 1'b0;
    end else begin
      // Nominal code is never touched by sleep, so leaving restores it
      o_core_vsel <= low_q ? core_red_q : core_nom_q;
      o_core_en   <= !(low_q && coreoff_q);
      o_low_power <= low_q;
      o_wait_mode <= sleep_s && (!adapter_s || aua_q);
    end
  end

  // ----------------------------------------------------------------
  // Processor reset pulse
  // ----------------------------------------------------------------
  assign rst_start = warm.rise && core_ok_s;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_q           <= '0;
      o_processor_reset_n <= 1'b1;
    end else begin
      if (rst_start) begin
        rst_cnt_q           <= CNT_W'(RST_LEN);
        o_processor_reset_n <= 1'b0;
      end else if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
        if (rst_cnt_q == CNT_W'(1)) begin
          o_processor_reset_n <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set = {low_q && exit_ev, warm.rise, btn.rise};

  // Set wins over the clear-on-read in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_st_q <= '0;
      o_irq    <= 1'b0;
    end else begin
      if (rd_fire && (araddr_q == ADDR_IRQST)) begin
        irq_st_q <= irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      o_irq <= |(irq_st_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
  assign wr_b0   = wr_fire && wstrb_q[0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
      awaddr_q        <= '0;
      wdata_q         <= '0;
      wstrb_q         <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        o_s_axi_awready <= 1'b0;
        awaddr_q        <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        o_s_axi_wready <= 1'b0;
        wdata_q        <= i_s_axi_wdata;
        wstrb_q        <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= lpm_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration fields all sit in byte lane 0
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      permit_q   <= 1'b0;
      core_nom_q <= CORE_NOM_RST;
      core_red_q <= CORE_RED_RST;
      coreoff_q  <= 1'b0;
      aua_q      <= 1'b0;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_b0) begin
      if (awaddr_q == ADDR_CONV1) begin
        permit_q   <= wdata_q[CONV1_PERMIT_BIT];
        core_nom_q <= wdata_q[CONV1_CORE_LSB +: CORE_W];
      end else if (awaddr_q == ADDR_CONV2) begin
        core_red_q <= wdata_q[CONV2_RED_LSB +: CORE_W];
        coreoff_q  <= wdata_q[CONV2_COREOFF_BIT];
      end else if (awaddr_q == ADDR_CHCFG) begin
        aua_q <= wdata_q[CHCFG_AUA_BIT];
      end else if (awaddr_q == ADDR_IRQMSK) begin
        irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_fire = !o_s_axi_arready && !o_s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr_q == ADDR_CONV1) begin
      rd_word[CONV1_PERMIT_BIT]            = permit_q;
      rd_word[CONV1_CORE_LSB +: CORE_W]    = core_nom_q;
      rd_word[CONV1_MAIN_BIT]              = o_main_3v3;
    end else if (araddr_q == ADDR_CONV2) begin
      rd_word[CONV2_RED_LSB +: CORE_W]     = core_red_q;
      rd_word[CONV2_COREOFF_BIT]           = coreoff_q;
    end else if (araddr_q == ADDR_CHCFG) begin
      rd_word[CHCFG_AUA_BIT]               = aua_q;
    end else if (araddr_q == ADDR_STATUS) begin
      rd_word[ST_LOW_BIT]                  = low_q;
      rd_word[ST_WAIT_BIT]                 = o_wait_mode;
      rd_word[ST_BTN_BIT]                  = btn.level;
      rd_word[ST_WARM_BIT]                 = warm.level;
      rd_word[ST_CORE_OK_BIT]              = core_ok_s;
    end else if (araddr_q == ADDR_IRQST) begin
      rd_word[IRQ_W-1:0]                   = irq_st_q;
    end else if (araddr_q == ADDR_IRQMSK) begin
      rd_word[IRQ_W-1:0]                   = irq_mask_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
      araddr_q        <= '0;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        araddr_q        <= i_s_axi_araddr;
      end
      if (rd_fire) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= rd_word;
        o_s_axi_rresp  <= lpm_mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_strap_main: assert property (strap_load |=> o_main_3v3 == $past(strap_s))
    else $error("main rail select does not follow strap");
  a_entry_edge: assert property ($rose(low_q) |-> $past(enter_rise))
    else $error("sleep entered without a rising gate edge");
  a_permit_gate: assert property (!permit_q |=> !low_q)
    else $error("sleep held with permit clear");
  a_core_reduced: assert property (low_q && !coreoff_q |=> o_core_vsel == $past(core_red_q) && o_core_en)
    else $error("core rail not at reduced code in sleep");
  a_core_off: assert property (low_q && coreoff_q |=> !o_core_en)
    else $error("core rail not off in sleep");
  a_exit_cause: assert property (low_q && exit_ev |=> !low_q)
    else $error("sleep not left on exit event");
  a_button_restore: assert property (low_q && btn.rise |=> ##1 o_core_vsel == $past(core_nom_q) && o_core_en)
    else $error("core voltage not restored after button exit");
  a_button_irq: assert property (btn.rise |=> irq_st_q[IRQ_BTN])
    else $error("button event not recorded");
  a_reset_pulse: assert property (rst_start |=> !o_processor_reset_n [*2])
    else $error("processor reset not asserted");
  a_reset_blocked: assert property (warm.rise && !core_ok_s && rst_cnt_q == '0 && o_processor_reset_n
    |=> o_processor_reset_n)
    else $error("processor reset asserted while core out of regulation");
  a_cfg_kept: assert property (warm.rise && !wr_fire |=> $stable(core_nom_q) && $stable(permit_q))
    else $error("warm restart altered configuration");

  c_enter_sleep: cover property (enter_rise ##1 low_q);
  c_core_off: cover property (low_q && coreoff_q ##1 !o_core_en);
  c_button_exit: cover property (low_q && btn.rise ##1 !low_q);
  c_reset_pulse: cover property ($fell(o_processor_reset_n));
endmodule

// ===== tb/lpm_host_model.sv
// Host and button side model driving the sleep and button pins.
// Assumes commands from the bench, applied at the rising clock edge.
`timescale 1ns/1ps
module lpm_host_model (
  input  wire logic i_clk,
  input  wire logic i_req_cmd,
  input  wire logic i_btn_cmd,
  input  wire logic i_warm_cmd,
  output logic      o_sleep_request,
  output logic      o_push_button,
  output logic      o_warm_restart_n
);
  // Idle levels follow the pin pulls: button low, warm restart high
  initial begin
    o_sleep_request  = 1'b0;
    o_push_button    = 1'b0;
    o_warm_restart_n = 1'b1;
  end
  always @(posedge i_clk) begin
    o_sleep_request  <= i_req_cmd;
    o_push_button    <= i_btn_cmd;
    o_warm_restart_n <= !i_warm_cmd;
  end
endmodule

// ===== tb/low_power_mode_control_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes short debounce and reset counts so the run stays brief.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module low_power_mode_control_tb
  import lpm_pkg::*;
;
  logic clk = 0, rst = 1, req = 0, btn = 0, warm = 0, strap = 1, cok = 1, adp = 0;
  logic sreq, pb, wrn, core_en, m33, prst_n, lp, wm, irq;
  logic [CORE_W-1:0] vsel;
  logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, resp;
  int err_total = 0, cmp_count = 0, n;
  initial forever #5 clk = ~clk;
  lpm_host_model host (.i_clk(clk), .i_req_cmd(req), .i_btn_cmd(btn), .i_warm_cmd(warm),
    .o_sleep_request(sreq), .o_push_button(pb), .o_warm_restart_n(wrn));
  lpm_ctrl #(.DBNC_LIMIT(8), .RST_LEN(5)) dut (.i_clk(clk), .i_rst(rst), .i_sleep_request(sreq),
    .i_push_button(pb), .i_warm_restart_n(wrn), .i_main_default_strap(strap),
    .i_core_in_reg(cok), .i_adapter_present(adp), .o_core_vsel(vsel), .o_core_en(core_en),
    .o_main_3v3(m33), .o_processor_reset_n(prst_n), .o_low_power(lp), .o_wait_mode(wm),
    .o_irq(irq), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 50) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    logic aw, w;
    k = 0; aw = 0; w = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awready) begin aw = 1; awvalid <= 0; end
      if (wready) begin w = 1; wvalid <= 0; end
      k++; bound(k);
    end
    do begin @(posedge clk); k++; bound(k); end while (bvalid !== 1'b1);
    resp = bresp; bready <= 0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    int k;
    k = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin @(posedge clk); k++; bound(k); end while (arready !== 1'b1);
    arvalid <= 0;
    do begin @(posedge clk); k++; bound(k); end while (rvalid !== 1'b1);
    rd = rdata; resp = rresp; rready <= 0;
    @(posedge clk);
  endtask
  // Pins cross two sync flops and an 8-cycle debounce; 30 cycles covers it
  task automatic settle();
    repeat (30) @(posedge clk);
  endtask
  task automatic press_btn();
    btn <= 1; repeat (20) @(posedge clk); btn <= 0; settle();
  endtask
  // Counts reset-low cycles while a 21-cycle warm press runs
  task automatic warm_count();
    n = 0; warm <= 1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (i == 20) warm <= 0;
      if (prst_n === 1'b0) n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(vsel, CORE_NOM_RST)
    `CHK(core_en, 1'b1)
    `CHK(m33, 1'b1)
    rdr(ADDR_CONV1);
    `CHK(rd[8], 1'b1)
    rdr(8'h20);
    `CHK(resp, RESP_SLVERR)
    wr(8'h20, 32'h1);
    `CHK(resp, RESP_SLVERR)
    $display("reset test done");
  endtask
  task automatic t_entry();
    req <= 1; settle();
    `CHK(lp, 1'b0)
    wr(ADDR_CONV1, 32'h71);
    `CHK(resp, RESP_OKAY)
    settle();
    `CHK(lp, 1'b1)
    `CHK(vsel, CORE_RED_RST)
    $display("entry test done");
  endtask
  task automatic t_button();
    wr(ADDR_IRQMSK, 32'h1); press_btn();
    `CHK(lp, 1'b0)
    `CHK(vsel, 4'h7)
    `CHK(irq, 1'b1)
    rdr(ADDR_IRQST);
    `CHK(rd[2:0], 3'h5)
    settle();
    `CHK(irq, 1'b0)
    `CHK(lp, 1'b0)
    $display("button test done");
  endtask
  task automatic t_coreoff();
    wr(ADDR_CONV2, 32'h13); req <= 0; settle(); req <= 1; settle();
    `CHK(lp, 1'b1)
    `CHK(core_en, 1'b0)
    wr(ADDR_CONV1, 32'h60); settle();
    `CHK(lp, 1'b0)
    `CHK(core_en, 1'b1)
    wr(ADDR_CONV1, 32'h61); settle();
    `CHK(lp, 1'b1)
    $display("core off test done");
  endtask
  task automatic t_warm();
    warm <= 1; repeat (4) @(posedge clk); warm <= 0; settle();
    `CHK(lp, 1'b1)
    `CHK(prst_n, 1'b1)
    warm_count();
    `CHK(n, 5)
    `CHK(lp, 1'b0)
    `CHK(irq, 1'b0)
    rdr(ADDR_CONV2);
    `CHK(rd[4:0], 5'h13)
    rdr(ADDR_IRQST);
    `CHK(rd[2:0], 3'h6)
    cok <= 0; warm_count();
    `CHK(n, 0)
    $display("warm restart test done");
  endtask
  task automatic t_wait();
    adp <= 1; req <= 0; settle(); req <= 1; settle();
    `CHK(wm, 1'b0)
    wr(ADDR_CHCFG, 32'h80); settle();
    `CHK(wm, 1'b1)
    $display("wait mode test done");
  endtask
  // Second reset with the strap low; config is cleared so sleep must stay off
  task automatic t_strap();
    strap <= 0;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (5) @(posedge clk);
    `CHK(m33, 1'b0)
    `CHK(lp, 1'b0)
    $display("strap test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (5) @(posedge clk);
    t_reset();
    t_entry();
    t_button();
    t_coreoff();
    t_warm();
    t_wait();
    t_strap();
    complete_run();
  end
endmodule
